// ===== rtl/usb_ifm_pkg.sv
// Constants for the USB interface module register set
package usb_ifm_pkg;
  // ************************************************************
  // Access and register offsets
  // ************************************************************
  localparam logic [7:0] PERIPH_ID   = 8'h01;
  localparam logic [7:0] OFF_RESET   = 8'h00;
  localparam logic [7:0] OFF_CTRL    = 8'h04;
  localparam logic [7:0] OFF_ADDR    = 8'h08;
  localparam logic [7:0] OFF_FUNC    = 8'h0c;
  localparam logic [7:0] OFF_OTG     = 8'h10;
  localparam logic [7:0] OFF_OTG_ST  = 8'h14;
  localparam logic [7:0] OFF_SERIAL  = 8'h18;
  localparam logic [7:0] OFF_FLAGS   = 8'h1c;
  localparam logic [7:0] OFF_STICKY  = 8'h20;
  // ************************************************************
  // Writable bit masks and reset values
  // ************************************************************
  localparam logic [7:0] CTRL_MASK   = 8'hf7;
  localparam logic [7:0] OTG_MASK    = 8'hdf;
  localparam logic [4:0] FUNC_RST    = 5'h07;
  localparam logic [3:0] SER_RST     = 4'h2;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTL_TOKEN   = 0;
  localparam int CTL_CHECK   = 1;
  localparam int CTL_LINEDEC = 2;
  localparam int CTL_TIMING  = 4;
  localparam int CTL_POWER   = 5;
  localparam int CTL_SOF     = 6;
  localparam int CTL_EVACK   = 7;
  localparam int FLG_TOKEN   = 6;
  localparam int FLG_SE0     = 5;
  localparam int FLG_K       = 4;
  localparam int FLG_J       = 3;
  localparam int FLG_CRC16   = 2;
  localparam int FLG_RXACT   = 1;
  localparam int FLG_RXERR   = 0;
  localparam int SYNC_W      = 22;
  // ************************************************************
  // Line states, packet ids and check values
  // ************************************************************
  localparam logic [1:0]  LS_SE0      = 2'h0;
  localparam logic [1:0]  LS_J        = 2'h1;
  localparam logic [1:0]  LS_K        = 2'h2;
  localparam logic [1:0]  PID_TOKEN   = 2'h1;
  localparam logic [1:0]  PID_DATA    = 2'h3;
  localparam logic [3:0]  PID_SOF     = 4'h5;
  localparam logic [4:0]  CRC5_INIT   = 5'h1f;
  localparam logic [4:0]  CRC5_POLY   = 5'h05;
  localparam logic [4:0]  CRC5_RES    = 5'h0c;
  localparam logic [15:0] CRC16_INIT  = 16'hffff;
  localparam logic [15:0] CRC16_POLY  = 16'h8005;
  localparam logic [15:0] CRC16_RES   = 16'h800d;
endpackage : usb_ifm_pkg

// ===== rtl/usb_packet_checker.sv
// Receive packet checker: token decode and data CRC check
`timescale 1ns/10ps
module usb_packet_checker
  import usb_ifm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  // Receive stream, already synchronised
  input  wire logic       rx_active,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  // Settings
  input  wire logic [6:0] dev_addr,
  input  wire logic       tok_en,
  input  wire logic       chk_en,
  input  wire logic       sof_en,
  // Events, one-cycle pulses
  output logic            pkt_start,
  output logic            token_ok,
  output logic            crc16_err
);
  typedef enum logic [1:0] {ST_IDLE, ST_PID, ST_BODY} chk_state_t;

  chk_state_t  state_q;
  logic        act_q;
  logic [7:0]  pid_q;
  logic [7:0]  tok_b0_q;
  logic [1:0]  cnt_q;
  logic [4:0]  crc5_q;
  logic [15:0] crc16_q;
  logic        pid_ok;
  logic        addr_ok;

  // Serial CRC steps, least significant bit first as on the wire
  function automatic logic [4:0] crc5_byte(input logic [4:0] c, input logic [7:0] d);
    logic [4:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = {r[3:0], 1'b0} ^ ((r[4] ^ d[i]) ? CRC5_POLY : 5'h00);
    end
    return r;
  endfunction : crc5_byte

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC16_POLY : 16'h0000);
    end
    return r;
  endfunction : crc16_byte

  assign pid_ok  = (pid_q[3:0] == ~pid_q[7:4]);
  // A start-of-frame carries no address; it passes only in its own mode
  assign addr_ok = (tok_b0_q[6:0] == dev_addr) || (sof_en && pid_q[3:0] == PID_SOF);

  // Byte collection across one packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      act_q    <= 1'b0;
      pid_q    <= 8'h00;
      tok_b0_q <= 8'h00;
      cnt_q    <= 2'h0;
      crc5_q   <= CRC5_INIT;
      crc16_q  <= CRC16_INIT;
    end else if (clr) begin
      state_q  <= ST_IDLE;
      act_q    <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      act_q <= rx_active;
      unique case (state_q)
        ST_IDLE: begin
          if (rx_active && !act_q) begin
            state_q <= ST_PID;
            cnt_q   <= 2'h0;
            crc5_q  <= CRC5_INIT;
            crc16_q <= CRC16_INIT;
          end
        end
        ST_PID: begin
          if (!rx_active) begin
            state_q <= ST_IDLE;
          end else if (rx_valid) begin
            pid_q   <= rx_data;
            state_q <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (!rx_active) begin
            state_q <= ST_IDLE;
          end else if (rx_valid) begin
            if (cnt_q == 2'h0) begin
              tok_b0_q <= rx_data;
            end
            if (cnt_q != 2'h3) begin
              cnt_q <= cnt_q + 2'h1;
            end
            crc5_q  <= crc5_byte(crc5_q, rx_data);
            crc16_q <= crc16_byte(crc16_q, rx_data);
          end
        end
      endcase
    end
  end

  // Verdicts are given when receive-active drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_start <= 1'b0;
      token_ok  <= 1'b0;
      crc16_err <= 1'b0;
    end else begin
      pkt_start <= !clr && rx_active && !act_q;
      token_ok  <= !clr && state_q == ST_BODY && !rx_active && tok_en
                   && pid_q[1:0] == PID_TOKEN && cnt_q == 2'h2 && addr_ok
                   && (!chk_en || (pid_ok && crc5_q == CRC5_RES));
      crc16_err <= !clr && state_q == ST_BODY && !rx_active
                   && pid_q[1:0] == PID_DATA && crc16_q != CRC16_RES;
    end
  end
endmodule : usb_packet_checker

// ===== rtl/usb_phy_interface_config.sv
// Register set of the USB interface module facing a UTMI+ transceiver
`timescale 1ns/10ps
// Behaviour
// - Any write to offset 0x00 resets module state
// - Control register holds mode enables, reset zero
// - Store 7-bit address; pass matching tokens, and any start-of-frame in its own mode
// - Functional control drives OpMode, TermSelect, XcvrSelect
// - OTG control drives pull, charge, VBUS lines
// - OTG status reflects transceiver session inputs
// - Serial control reads back D+, D-, receiver
// - Serial control drives transmit controls, enable low
// - Bits 6 to 2 clear at next packet unless sticky
// - Bit 6 set on good matching token
// - Bits 5,4,3 set on SE0, K, J
// - Bit 2 set on data CRC16 failure
// - Bits 1,0 follow receive active and error
// - Reached only as peripheral 1, 32-bit
// - Stickiness mask; sticky flag cleared writing one
module usb_phy_interface_config
  import usb_ifm_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // Peripheral register access
  input  wire logic [7:0]  PERIPH_NUM,
  input  wire logic [7:0]  PERIPH_ADDR,
  input  wire logic        PERIPH_WR,
  input  wire logic        PERIPH_RD,
  input  wire logic [31:0] PERIPH_WDATA,
  output logic      [31:0] PERIPH_RDATA,
  output logic             PERIPH_ACK,
  // Transceiver receive side
  input  wire logic [7:0]  UTMI_RXDATA,
  input  wire logic        UTMI_RXVALID,
  input  wire logic        UTMI_RXACTIVE,
  input  wire logic        UTMI_RXERROR,
  input  wire logic [1:0]  UTMI_LINESTATE,
  input  wire logic        UTMI_RX_DP,
  input  wire logic        UTMI_RX_DM,
  input  wire logic        UTMI_RX_RCV,
  // Transceiver on-the-go status
  input  wire logic        UTMI_SESS_END,
  input  wire logic        UTMI_SESS_VALID,
  input  wire logic        UTMI_VBUS_VALID,
  input  wire logic        UTMI_HOST_DISCON,
  input  wire logic        UTMI_ID_DIG,
  input  wire logic        UTMI_B_VALID,
  // Transceiver functional controls
  output logic      [2:0]  UTMI_OPMODE,
  output logic             UTMI_TERMSELECT,
  output logic             UTMI_XCVRSELECT,
  // Transceiver on-the-go controls
  output logic             UTMI_ID_PULLUP,
  output logic             UTMI_DP_PULLDOWN,
  output logic             UTMI_DM_PULLDOWN,
  output logic             UTMI_DISCHRG_VBUS,
  output logic             UTMI_CHRG_VBUS,
  output logic             EXT_VBUS_DRIVE,
  output logic             EXT_VBUS_IND_SEL,
  // Transceiver serial controls
  output logic             UTMI_FSLS_SERIAL,
  output logic             UTMI_TX_ENABLE_N,
  output logic             UTMI_TX_DATA,
  output logic             UTMI_TX_SE0,
  // Engine modes for neighbouring logic
  output logic             IF_TIMING_MODE,
  output logic             POWER_SIGNAL_MODE,
  output logic             FRAME_START_AS_TOKEN_MODE,
  output logic             EVENT_ACK_MODE
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [7:0]        rx_data_s;
  logic              rx_valid_s;
  logic              rx_act_s;
  logic              rx_err_s;
  logic [1:0]        line_s;
  logic [2:0]        rx_line_s;
  logic [5:0]        otg_s;
  logic              acc;
  logic              wr;
  logic              rd;
  logic              clr;
  logic [7:0]        ctrl_q;
  logic [6:0]        addr_q;
  logic [4:0]        func_q;
  logic [7:0]        otg_q;
  logic [3:0]        ser_q;
  logic [6:0]        flags_q;
  logic [6:0]        sticky_q;
  logic [6:0]        ev;
  logic [6:0]        w1c;
  logic [31:0]       rdata_d;
  logic [31:0]       rdata_q;
  logic              ack_q;
  logic              pkt_start;
  logic              token_ok;
  logic              crc16_err;

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  // Two flops on every transceiver input; the receive byte is
  // sampled together with its valid, so skew is limited to one
  // cycle and is tolerated only because the link is much slower.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {UTMI_RXDATA, UTMI_RXVALID, UTMI_RXACTIVE, UTMI_RXERROR,
                  UTMI_LINESTATE, UTMI_RX_RCV, UTMI_RX_DM, UTMI_RX_DP,
                  UTMI_B_VALID, UTMI_ID_DIG, UTMI_HOST_DISCON,
                  UTMI_VBUS_VALID, UTMI_SESS_VALID, UTMI_SESS_END};
      sync2_q <= sync1_q;
    end
  end

  assign rx_data_s  = sync2_q[21:14];
  assign rx_valid_s = sync2_q[13];
  assign rx_act_s   = sync2_q[12];
  assign rx_err_s   = sync2_q[11];
  assign line_s     = sync2_q[10:9];
  assign rx_line_s  = sync2_q[8:6];
  assign otg_s      = sync2_q[5:0];

  // ************************************************************
  // Access decode
  // ************************************************************
  // Other peripheral numbers are simply not ours and get no answer
  assign acc = (PERIPH_NUM == PERIPH_ID) && (PERIPH_WR || PERIPH_RD);
  assign wr  = acc && PERIPH_WR;
  assign rd  = acc && PERIPH_RD && !PERIPH_WR;
  assign clr = wr && (PERIPH_ADDR == OFF_RESET);
  assign w1c = (wr && PERIPH_ADDR == OFF_FLAGS) ? PERIPH_WDATA[6:0] : 7'h00;

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Control enables; reserved bit 3 never stores
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 8'h00;
    end else if (clr) begin
      ctrl_q <= 8'h00;
    end else if (wr && PERIPH_ADDR == OFF_CTRL) begin
      ctrl_q <= PERIPH_WDATA[7:0] & CTRL_MASK;
    end
  end

  // Device address for token filtering
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_q <= 7'h00;
    end else if (clr) begin
      addr_q <= 7'h00;
    end else if (wr && PERIPH_ADDR == OFF_ADDR) begin
      addr_q <= PERIPH_WDATA[6:0];
    end
  end

  // Functional control, each field reset to one
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      func_q <= FUNC_RST;
    end else if (clr) begin
      func_q <= FUNC_RST;
    end else if (wr && PERIPH_ADDR == OFF_FUNC) begin
      func_q <= PERIPH_WDATA[4:0];
    end
  end

  // On-the-go control; reserved bit 5 never stores
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      otg_q <= 8'h00;
    end else if (clr) begin
      otg_q <= 8'h00;
    end else if (wr && PERIPH_ADDR == OFF_OTG) begin
      otg_q <= PERIPH_WDATA[7:0] & OTG_MASK;
    end
  end

  // Serial transmit controls; transmit enable idles high
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ser_q <= SER_RST;
    end else if (clr) begin
      ser_q <= SER_RST;
    end else if (wr && PERIPH_ADDR == OFF_SERIAL) begin
      ser_q <= PERIPH_WDATA[3:0];
    end
  end

  // Stickiness mask, one bit per flag
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sticky_q <= 7'h00;
    end else if (clr) begin
      sticky_q <= 7'h00;
    end else if (wr && PERIPH_ADDR == OFF_STICKY) begin
      sticky_q <= PERIPH_WDATA[6:0];
    end
  end

  // ************************************************************
  // Line and error flags
  // ************************************************************
  usb_packet_checker u_checker (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .clr       (clr),
    .rx_active (rx_act_s),
    .rx_valid  (rx_valid_s),
    .rx_data   (rx_data_s),
    .dev_addr  (addr_q),
    .tok_en    (ctrl_q[CTL_TOKEN]),
    .chk_en    (ctrl_q[CTL_CHECK]),
    .sof_en    (ctrl_q[CTL_SOF]),
    .pkt_start (pkt_start),
    .token_ok  (token_ok),
    .crc16_err (crc16_err)
  );

  // Line symbols are only decoded while the decoder is enabled
  always_comb begin
    ev            = 7'h00;
    ev[FLG_TOKEN] = token_ok;
    ev[FLG_SE0]   = ctrl_q[CTL_LINEDEC] && line_s == LS_SE0;
    ev[FLG_K]     = ctrl_q[CTL_LINEDEC] && line_s == LS_K;
    ev[FLG_J]     = ctrl_q[CTL_LINEDEC] && line_s == LS_J;
    ev[FLG_CRC16] = crc16_err;
    ev[FLG_RXACT] = rx_act_s;
    ev[FLG_RXERR] = rx_err_s;
  end

  // Per flag update; an event beats a write-one clear or packet start in the same cycle, but a reset write beats the event
  for (genvar i = 0; i < 7; i++) begin : g_flag
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        flags_q[i] <= 1'b0;
      end else if (clr) begin
        flags_q[i] <= 1'b0;
      end else if (sticky_q[i]) begin
        flags_q[i] <= ev[i] || (flags_q[i] && !w1c[i]);
      end else if (i <= FLG_RXACT) begin
        flags_q[i] <= ev[i];
      end else begin
        flags_q[i] <= ev[i] || (flags_q[i] && !w1c[i] && !pkt_start);
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Unmapped and write-only offsets read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (PERIPH_ADDR)
      OFF_CTRL:   rdata_d[7:0] = ctrl_q;
      OFF_ADDR:   rdata_d[6:0] = addr_q;
      OFF_FUNC:   rdata_d[4:0] = func_q;
      OFF_OTG:    rdata_d[7:0] = otg_q;
      OFF_OTG_ST: rdata_d[5:0] = otg_s;
      OFF_SERIAL: rdata_d[6:0] = {rx_line_s, ser_q};
      OFF_FLAGS:  rdata_d[6:0] = flags_q;
      OFF_STICKY: rdata_d[6:0] = sticky_q;
      default:    rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data holds until the next read; ack marks every access
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= acc;
      if (rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ************************************************************
  // Outputs, all straight from flops
  // ************************************************************
  assign PERIPH_RDATA              = rdata_q;
  assign PERIPH_ACK                = ack_q;
  assign UTMI_OPMODE               = func_q[4:2];
  assign UTMI_TERMSELECT           = func_q[1];
  assign UTMI_XCVRSELECT           = func_q[0];
  assign UTMI_ID_PULLUP            = otg_q[0];
  assign UTMI_DP_PULLDOWN          = otg_q[1];
  assign UTMI_DM_PULLDOWN          = otg_q[2];
  assign UTMI_DISCHRG_VBUS         = otg_q[3];
  assign UTMI_CHRG_VBUS            = otg_q[4];
  assign EXT_VBUS_DRIVE            = otg_q[6];
  assign EXT_VBUS_IND_SEL          = otg_q[7];
  assign UTMI_FSLS_SERIAL          = ser_q[0];
  assign UTMI_TX_ENABLE_N          = ser_q[1];
  assign UTMI_TX_DATA              = ser_q[2];
  assign UTMI_TX_SE0               = ser_q[3];
  assign IF_TIMING_MODE            = ctrl_q[CTL_TIMING];
  assign POWER_SIGNAL_MODE         = ctrl_q[CTL_POWER];
  assign FRAME_START_AS_TOKEN_MODE = ctrl_q[CTL_SOF];
  assign EVENT_ACK_MODE            = ctrl_q[CTL_EVACK];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_reset_write;
    wr && PERIPH_ADDR == OFF_RESET;
  endsequence
  sequence s_back_to_reset;
    ##1 ctrl_q == 8'h00 && addr_q == 7'h00 && func_q == FUNC_RST
    && ser_q == SER_RST && flags_q == 7'h00;
  endsequence

  a_module_reset: assert property (s_reset_write |-> s_back_to_reset)
    else $error("Reset write did not restore state");
  a_ctrl_store: assert property (wr && PERIPH_ADDR == OFF_CTRL |=>
    ctrl_q == ($past(PERIPH_WDATA[7:0]) & CTRL_MASK) && !ctrl_q[3])
    else $error("Control register store wrong");
  a_addr_read: assert property (rd && PERIPH_ADDR == OFF_ADDR |=>
    PERIPH_ACK && PERIPH_RDATA == {25'h0, $past(addr_q)})
    else $error("Address readback wrong");
  a_func_pins: assert property ($rose(RST_N) || $past(clr) |->
    UTMI_OPMODE == 3'h1 && UTMI_TERMSELECT && UTMI_XCVRSELECT)
    else $error("Functional controls not at reset value");
  a_otg_pins: assert property (wr && PERIPH_ADDR == OFF_OTG |=>
    EXT_VBUS_DRIVE == $past(PERIPH_WDATA[6]) && UTMI_ID_PULLUP == $past(PERIPH_WDATA[0]))
    else $error("On-the-go controls not driven");
  a_otg_status: assert property (rd && PERIPH_ADDR == OFF_OTG_ST |=>
    PERIPH_RDATA[5:0] == $past(sync2_q[5:0]) && PERIPH_RDATA[31:6] == 26'h0)
    else $error("On-the-go status readback wrong");
  a_serial_read: assert property (rd && PERIPH_ADDR == OFF_SERIAL |=>
    PERIPH_RDATA[6:4] == $past(sync2_q[8:6]))
    else $error("Serial line status readback wrong");
  a_tx_enable: assert property (wr && PERIPH_ADDR == OFF_SERIAL && !PERIPH_WDATA[1] |=>
    !UTMI_TX_ENABLE_N)
    else $error("Transmit enable not driven low");
  a_flag_autoclr: assert property (pkt_start && !clr |=>
    (flags_q & ~$past(sticky_q) & ~$past(ev) & 7'h7c) == 7'h00)
    else $error("Non-sticky flag survived packet start");
  a_token_flag: assert property (token_ok && !clr |=> flags_q[6])
    else $error("Token flag not set");
  a_line_se0: assert property (ctrl_q[2] && line_s == 2'h0 && !clr |=> flags_q[5])
    else $error("Single-ended zero flag not set");
  a_crc16_flag: assert property (crc16_err && !clr |=> flags_q[2])
    else $error("Data CRC flag not set");
  a_rx_follow: assert property (!clr && !sticky_q[1] |=> flags_q[1] == $past(rx_act_s))
    else $error("Receive-active flag not following");
  a_other_periph: assert property ((PERIPH_WR || PERIPH_RD) && PERIPH_NUM != PERIPH_ID |=>
    !PERIPH_ACK)
    else $error("Answered another peripheral");
  a_sticky_hold: assert property (!clr |=>
    ($past(sticky_q) & $past(flags_q) & ~$past(w1c) & ~flags_q) == 7'h00)
    else $error("Sticky flag lost");
  a_reserved_zero: assert property (rd && PERIPH_ADDR == OFF_FLAGS |=>
    PERIPH_RDATA[31:7] == 25'h0)
    else $error("Reserved bits read nonzero");
endmodule : usb_phy_interface_config

// ===== testbench/utmi_phy_model.sv
// Behavioural UTMI+ transceiver receive side that sends three-byte packets
`timescale 1ns/10ps
module utmi_phy_model (
  // Clock
  input  wire logic       clk,
  // Receive stream towards the block
  output logic            act,
  output logic            vld,
  output logic [7:0]      dat
);
  // Idle bus; data is scrambled when not valid so a stale byte never looks real
  initial begin
    act = 1'b0;
    vld = 1'b0;
    dat = 8'h00;
  end
  // Packet framed by receive active, bytes back to back, PID first
  task send(input logic [23:0] p);
    integer i;
    @(negedge clk) act = 1'b1;
    repeat (2) @(negedge clk);
    for (i = 0; i < 3; i++) begin
      vld = 1'b1;
      dat = p[23-8*i -: 8];
      @(negedge clk);
    end
    vld = 1'b0;
    dat = ~dat;
    repeat (2) @(negedge clk);
    act = 1'b0;
    repeat (9) @(negedge clk);
  endtask : send
endmodule : utmi_phy_model

// ===== testbench/test_usb_phy_interface_config.sv
// Self-checking bench for the USB interface module register set
`timescale 1ns/10ps
module test_usb_phy_interface_config;
  import usb_ifm_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rxerr = 0;
  logic [7:0]  num = 8'h01, ad = 8'h00;
  logic [31:0] wd = 0, q;
  logic [1:0]  ls = LS_SE0;
  logic [5:0]  otg = 0;
  logic [2:0]  rx = 0;
  wire logic   act, vld, ack, ind, tx_en_n, evk;
  wire logic [13:0] pv;
  wire logic [7:0]  dat;
  wire logic [2:0]  opm;
  wire logic [31:0] rdata;
  int          error_cnt = 0, check_count = 0, cyc = 0, i;
  // Offsets with reset values and read-back after writing all ones
  logic [7:0]  offs [7] = '{OFF_CTRL, OFF_ADDR, OFF_FUNC, OFF_OTG, OFF_OTG_ST, OFF_SERIAL, 8'h24};
  logic [31:0] rv [7] = '{0, 0, 32'h07, 0, 0, 32'h02, 0};
  logic [31:0] wv [7] = '{32'hf7, 32'h7f, 32'h1f, 32'hdf, 0, 32'h0f, 0};
  usb_phy_interface_config usb_phy_interface_config_i (.SYS_CLK(clk), .RST_N(rst_n),
    .PERIPH_NUM(num), .PERIPH_ADDR(ad), .PERIPH_WR(wr), .PERIPH_RD(rd), .PERIPH_WDATA(wd),
    .PERIPH_RDATA(rdata), .PERIPH_ACK(ack), .UTMI_RXDATA(dat), .UTMI_RXVALID(vld),
    .UTMI_RXACTIVE(act), .UTMI_RXERROR(rxerr), .UTMI_LINESTATE(ls), .UTMI_RX_DP(rx[0]),
    .UTMI_RX_DM(rx[1]), .UTMI_RX_RCV(rx[2]), .UTMI_SESS_END(otg[0]), .UTMI_SESS_VALID(otg[1]),
    .UTMI_VBUS_VALID(otg[2]), .UTMI_HOST_DISCON(otg[3]), .UTMI_ID_DIG(otg[4]),
    .UTMI_B_VALID(otg[5]), .UTMI_OPMODE(opm), .UTMI_TERMSELECT(pv[0]), .UTMI_XCVRSELECT(pv[1]),
    .UTMI_ID_PULLUP(pv[2]), .UTMI_DP_PULLDOWN(pv[3]), .UTMI_DM_PULLDOWN(pv[4]),
    .UTMI_DISCHRG_VBUS(pv[5]), .UTMI_CHRG_VBUS(pv[6]), .EXT_VBUS_DRIVE(pv[7]),
    .EXT_VBUS_IND_SEL(ind), .UTMI_FSLS_SERIAL(pv[8]), .UTMI_TX_ENABLE_N(tx_en_n),
    .UTMI_TX_DATA(pv[9]), .UTMI_TX_SE0(pv[10]), .IF_TIMING_MODE(pv[11]),
    .POWER_SIGNAL_MODE(pv[12]), .FRAME_START_AS_TOKEN_MODE(pv[13]), .EVENT_ACK_MODE(evk));
  utmi_phy_model utmi_phy_model_i (.clk(clk), .act(act), .vld(vld), .dat(dat));
  // Clock of 100 ns and a cycle ceiling against hangs
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task ck(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : ck
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // One strobe cycle; answer and data are taken one cycle later
  task acc(input logic wn, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {wr, rd, ad, wd} = {wn, !wn, a, d};
    @(negedge clk);
    {wr, rd} = 2'b00;
    q = rdata;
    ck("ack", {31'h0, num == 8'h01}, {31'h0, ack});
  endtask : acc
  task rst_chk;
    for (i = 0; i < 7; i++) begin
      acc(0, offs[i], 0);
      ck("reset value", rv[i], q);
    end
    ck("opmode", 32'h1, {29'h0, opm});
    ck("tx enable", 32'h1, {31'h0, tx_en_n});
    ck("control pins", 32'h3, {18'h0, pv});
  endtask : rst_chk
  task t_regs;
    rst_chk();
    for (i = 0; i < 7; i++) begin
      acc(1, offs[i], 32'hffffffff);
      acc(0, offs[i], 0);
      ck("read back", wv[i], q);
    end
    ck("pins", 32'hfffff, {12'h0, pv, opm, tx_en_n, evk, ind});
    num = 8'h02;
    acc(1, OFF_CTRL, 0);
    num = 8'h01;
    acc(0, OFF_CTRL, 0);
    ck("other peripheral", 32'hf7, q);
    acc(1, OFF_RESET, 32'h0);
    rst_chk();
    $display("t_regs done");
  endtask : t_regs
  task t_stat;
    otg = 6'h2d;
    rx = 3'b101;
    w(4);
    acc(0, OFF_OTG_ST, 0);
    ck("otg status", 32'h2d, q);
    acc(0, OFF_SERIAL, 0);
    ck("serial", 32'h52, q);
    $display("t_stat done");
  endtask : t_stat
  // Read the flags after a settling gap
  task fl(input logic [31:0] e);
    w(5);
    acc(0, OFF_FLAGS, 0);
    ck("flags", e, q);
  endtask : fl
  task t_flags;
    ls = LS_J;
    acc(1, OFF_CTRL, 32'h05);
    acc(1, OFF_ADDR, 32'h05);
    fl(32'h08);
    ls = LS_K;
    fl(32'h18);
    ls = LS_SE0;
    fl(32'h38);
    acc(1, OFF_CTRL, 32'h01);
    acc(1, OFF_FLAGS, 32'hffffffff);
    fl(32'h00);
    rxerr = 1;
    fl(32'h01);
    rxerr = 0;
    fl(32'h00);
    utmi_phy_model_i.send(24'he10600);
    fl(32'h00);
    utmi_phy_model_i.send(24'he10500);
    fl(32'h40);
    utmi_phy_model_i.send(24'hc30001);
    fl(32'h04);
    acc(1, OFF_STICKY, 32'h40);
    utmi_phy_model_i.send(24'he10500);
    utmi_phy_model_i.send(24'hc30001);
    fl(32'h44);
    acc(1, OFF_FLAGS, 32'h40);
    fl(32'h04);
    $display("t_flags done");
  endtask : t_flags
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Reset for six cycles, then the scenarios
  initial begin
    w(6);
    rst_n = 1;
    t_regs();
    t_stat();
    t_flags();
    stop_test();
  end
endmodule : test_usb_phy_interface_config
